// >>> inc/pao_defs.svh
// constants for the pipelined converter output path
`ifndef PAO_DEFS_SVH
`define PAO_DEFS_SVH

`define PAO_CODE_W       4
`define PAO_STAGES       4
`define PAO_RES_W        12
`define PAO_SUM_W        14
`define PAO_DLY_BASE     4
`define PAO_FILL_TICKS   2'h2
`define PAO_W_STAGE0     9
`define PAO_W_STAGE1     6
`define PAO_W_STAGE2     3
`define PAO_W_STAGE3     0
`define PAO_EC_OFFSET    14'h0249
`define PAO_CODE_MAX     14'h0FFF
`define PAO_WORD_ONES    12'hFFF
`define PAO_WORD_ZEROS   12'h000
`define PAO_PHASE_SAMPLE 1'h0
`define PAO_PHASE_HOLD   1'h1
`define PAO_BUF_DEPTH    2'h2

`endif

// >>> inc/pao_pkg.sv
// types for the pipelined converter output path
package pao_pkg;

    typedef logic [3:0]  pao_code_t;
    typedef logic [11:0] pao_word_t;

    typedef struct packed {
        pao_code_t stage3;
        pao_code_t stage2;
        pao_code_t stage1;
        pao_code_t stage0;
    } pao_codes_t;

    typedef struct packed {
        pao_word_t word;
    } pao_result_t;

    typedef enum logic {
        PAO_FILL,
        PAO_RUN
    } pao_state_t;

endpackage : pao_pkg

// >>> design/pao_skid_buffer.sv
// two-entry buffer between correction and output latch
`timescale 1ns/1ps
`default_nettype none
`include "pao_defs.svh"

module pao_skid_buffer
    import pao_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // filling side
    input  wire pao_result_t in_data,
    input  wire logic        in_valid,
    output logic             in_ready,
    // draining side
    output pao_result_t      out_data,
    output logic             out_valid,
    input  wire logic        out_ready
);

    // ----------------------------------------
    // storage
    // ----------------------------------------
    pao_result_t mem_reg [0:1];
    logic        wr_ptr_reg;
    logic        rd_ptr_reg;
    logic [1:0]  count_reg;
    logic [1:0]  count_next;
    wire         push = in_valid && in_ready;
    wire         pop  = out_valid && out_ready;

    assign in_ready  = (count_reg != `PAO_BUF_DEPTH);
    assign out_valid = (count_reg != 2'h0);
    assign out_data  = mem_reg[rd_ptr_reg];

    assign count_next = count_reg + {1'b0, push} - {1'b0, pop};

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg ^ push;
            rd_ptr_reg <= rd_ptr_reg ^ pop;
            count_reg  <= count_next;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
        end else if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

endmodule : pao_skid_buffer
`default_nettype wire

// >>> design/pao_output_path.sv
// digital output path of a pipelined sampling converter
`timescale 1ns/1ps
`default_nettype none
`include "pao_defs.svh"

module pao_output_path
    import pao_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // stage codes from the converter core
    input  wire pao_codes_t stage_code,
    // host side
    input  wire logic       host_ready,
    // internal phases
    output logic            sample_phase,
    output logic            hold_phase,
    // result bus
    output logic [11:0]     result_line,
    output logic            result_valid,
    // buffer status
    output logic            accept_ready,
    output logic            overrun
);

    // ----------------------------------------
    // phase generator
    // ----------------------------------------
    logic phase_reg;
    logic phase_next;
    logic sample_phase_reg;
    logic sample_phase_next;
    logic hold_phase_reg;
    logic hold_phase_next;

    // one clk is one half period
    assign phase_next        = ~phase_reg;
    // phases never overlap, both low in reset
    assign sample_phase_next = (phase_reg == `PAO_PHASE_HOLD);
    assign hold_phase_next   = (phase_reg == `PAO_PHASE_SAMPLE);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phase_reg <= `PAO_PHASE_SAMPLE;
        end else begin
            phase_reg <= phase_next;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sample_phase_reg <= 1'b0;
            hold_phase_reg   <= 1'b0;
        end else begin
            sample_phase_reg <= sample_phase_next;
            hold_phase_reg   <= hold_phase_next;
        end
    end

    assign sample_phase = sample_phase_reg;
    assign hold_phase   = hold_phase_reg;

    // ----------------------------------------
    // period strobes
    // ----------------------------------------
    wire sample_edge;
    wire period_end;

    // end of sample phase is the sample command
    assign sample_edge = (phase_reg == `PAO_PHASE_SAMPLE);
    // end of hold phase closes one period
    assign period_end  = (phase_reg == `PAO_PHASE_HOLD);

    // ----------------------------------------
    // stage codes as an array
    // ----------------------------------------
    pao_code_t code_in [0:3];

    assign code_in[0] = stage_code.stage0;
    assign code_in[1] = stage_code.stage1;
    assign code_in[2] = stage_code.stage2;
    assign code_in[3] = stage_code.stage3;

    // ----------------------------------------
    // alignment delay lines
    // ----------------------------------------
    pao_code_t aligned [0:3];

    // stage m arrives one half later than m-1
    genvar m;
    generate
        for (m = 0; m < `PAO_STAGES; m = m + 1) begin : g_dly
            localparam int LEN = `PAO_DLY_BASE - m;
            pao_code_t dly_reg [0:LEN-1];

            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    for (int i = 0; i < LEN; i++) begin
                        dly_reg[i] <= '0;
                    end
                end else begin
                    dly_reg[0] <= code_in[m];
                    for (int i = 1; i < LEN; i++) begin
                        dly_reg[i] <= dly_reg[i-1];
                    end
                end
            end

            assign aligned[m] = dly_reg[LEN-1];
        end
    endgenerate

    // ----------------------------------------
    // error correction
    // ----------------------------------------
    logic [13:0] term0;
    logic [13:0] term1;
    logic [13:0] term2;
    logic [13:0] term3;
    logic [13:0] code_sum;
    logic [13:0] code_fix;
    wire         under_range;
    wire         over_range;
    pao_result_t corrected;

    // overlapping weights use the redundant bit
    assign term0 = 14'({10'h000, aligned[0]} << `PAO_W_STAGE0);
    assign term1 = 14'({10'h000, aligned[1]} << `PAO_W_STAGE1);
    assign term2 = 14'({10'h000, aligned[2]} << `PAO_W_STAGE2);
    assign term3 = 14'({10'h000, aligned[3]} << `PAO_W_STAGE3);

    assign code_sum = term0 + term1 + term2 + term3;

    assign under_range = (code_sum < `PAO_EC_OFFSET);
    assign code_fix    = code_sum - `PAO_EC_OFFSET;
    assign over_range  = !under_range && (code_fix > `PAO_CODE_MAX);

    // clamp at both full scale ends
    assign corrected.word = under_range ? `PAO_WORD_ZEROS
                          : over_range  ? `PAO_WORD_ONES
                          : code_fix[11:0];

    // ----------------------------------------
    // pipeline fill control
    // ----------------------------------------
    pao_state_t state_reg;
    pao_state_t state_next;
    logic [1:0] fill_cnt_reg;
    logic [1:0] fill_cnt_next;
    wire        fill_done;
    wire        push_word;

    // first aligned word is ready at third period end
    assign fill_done = (fill_cnt_reg == `PAO_FILL_TICKS);

    always_comb begin
        state_next    = state_reg;
        fill_cnt_next = fill_cnt_reg;
        case (state_reg)
            PAO_FILL: begin
                if (period_end) begin
                    if (fill_done) begin
                        state_next = PAO_RUN;
                    end else begin
                        fill_cnt_next = fill_cnt_reg + 2'h1;
                    end
                end
            end
            PAO_RUN: begin
                state_next = PAO_RUN;
            end
            default: begin
                state_next = PAO_FILL;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg    <= PAO_FILL;
            fill_cnt_reg <= 2'h0;
        end else begin
            state_reg    <= state_next;
            fill_cnt_reg <= fill_cnt_next;
        end
    end

    // one word per period once filled
    assign push_word = period_end && ((state_reg == PAO_RUN) || fill_done);

    // ----------------------------------------
    // buffer
    // ----------------------------------------
    pao_result_t buf_data;
    logic        buf_valid;
    logic        buf_in_ready;
    wire         drain;

    // drained on the sample command edge
    assign drain = sample_edge && host_ready;

    pao_skid_buffer u_buffer (
        .clk       (clk),
        .resetn    (resetn),
        .in_data   (corrected),
        .in_valid  (push_word),
        .in_ready  (buf_in_ready),
        .out_data  (buf_data),
        .out_valid (buf_valid),
        .out_ready (drain)
    );

    // ----------------------------------------
    // status flags
    // ----------------------------------------
    logic accept_ready_reg;
    logic accept_ready_next;
    logic overrun_reg;
    logic overrun_next;
    wire  lost_word;

    // core cannot stall, a refused word is lost
    assign lost_word         = push_word && !buf_in_ready;
    assign accept_ready_next = buf_in_ready;
    assign overrun_next      = lost_word;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            accept_ready_reg <= 1'b0;
            overrun_reg      <= 1'b0;
        end else begin
            accept_ready_reg <= accept_ready_next;
            overrun_reg      <= overrun_next;
        end
    end

    assign accept_ready = accept_ready_reg;
    assign overrun      = overrun_reg;

    // ----------------------------------------
    // output latch
    // ----------------------------------------
    pao_result_t out_reg;
    pao_result_t out_next;
    logic        out_valid_reg;
    logic        out_valid_next;
    wire         load_word;

    assign load_word      = drain && buf_valid;
    assign out_next       = load_word ? buf_data : out_reg;
    // valid only after fill, for one period per word while host_ready is high
    assign out_valid_next = drain ? buf_valid : out_valid_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            out_reg <= '0;
        end else begin
            out_reg <= out_next;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            out_valid_reg <= 1'b0;
        end else begin
            out_valid_reg <= out_valid_next;
        end
    end

    // msb on the highest line
    assign result_line  = out_reg.word;
    assign result_valid = out_valid_reg;

endmodule : pao_output_path
`default_nettype wire

// >>> test/pao_output_path_asserts.sv
// concurrent checks on the converter output path ports
`timescale 1ns/1ps
`default_nettype none

module pao_output_path_asserts
    import pao_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        resetn,
    // inputs
    input wire pao_codes_t  stage_code,
    input wire logic        host_ready,
    // outputs
    input wire logic        sample_phase,
    input wire logic        hold_phase,
    input wire logic [11:0] result_line,
    input wire logic        result_valid,
    input wire logic        accept_ready,
    input wire logic        overrun
);
    // ----------------------------------------
    // cycles since reset release
    // ----------------------------------------
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;

    assign cnt_next = (cnt_reg == 4'hF) ? cnt_reg : cnt_reg + 4'h1;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) cnt_reg <= 4'h0;
        else cnt_reg <= cnt_next;
    end

    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_fresh;
        resetn [*2];
    endsequence
    sequence s_stall;
        sample_phase && !host_ready;
    endsequence

    a_phase_excl: assert property (!(sample_phase && hold_phase))
        else $error("phases overlap");
    a_phase_live: assert property (s_fresh |-> (sample_phase ^ hold_phase))
        else $error("no phase active");
    a_phase_alt: assert property (hold_phase |=> sample_phase)
        else $error("hold not followed by sample");
    a_phase_turn: assert property (sample_phase |=> hold_phase)
        else $error("sample not followed by hold");
    a_reset_clear: assert property ($rose(resetn) |-> result_line == 12'h000 && !result_valid && !overrun)
        else $error("outputs not clear after reset");
    a_load_edge: assert property ($changed(result_line) |-> hold_phase)
        else $error("word changed off the sample edge");
    a_first_word: assert property ($rose(result_valid) |-> cnt_reg == 4'h7)
        else $error("first word at wrong cycle");
    a_valid_keep: assert property (result_valid |=> result_valid)
        else $error("valid dropped in stream");
    a_stall_hold: assert property (s_stall |=> $stable(result_line) && $stable(result_valid))
        else $error("word moved while host stalled");
    a_ovr_pulse: assert property (overrun |=> !overrun)
        else $error("overrun longer than one cycle");
    a_ovr_full: assert property (overrun |-> !accept_ready)
        else $error("overrun while buffer not full");
endmodule : pao_output_path_asserts

bind pao_output_path pao_output_path_asserts pao_output_path_asserts_i (
    .clk(clk), .resetn(resetn), .stage_code(stage_code), .host_ready(host_ready),
    .sample_phase(sample_phase), .hold_phase(hold_phase), .result_line(result_line),
    .result_valid(result_valid), .accept_ready(accept_ready), .overrun(overrun)
);

`default_nettype wire

// >>> test/pao_host_model.sv
// host logic that captures result words
`timescale 1ns/1ps
`default_nettype none

module pao_host_model
    import pao_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // bench control
    input  wire logic        stall,
    // result bus
    input  wire logic [11:0] result_line,
    input  wire logic        result_valid,
    output logic             host_ready,
    output logic [15:0]      cyc_cnt,
    output logic [11:0]      word_seen
);
    logic [11:0] word_reg;

    assign host_ready = !stall;
    assign word_seen  = word_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cyc_cnt  <= 16'h0000;
            word_reg <= 12'h000;
        end else begin
            cyc_cnt <= cyc_cnt + 16'h0001;
            if (result_valid && cyc_cnt >= 16'h0007) word_reg <= result_line;
        end
    end
endmodule : pao_host_model

`default_nettype wire

// >>> test/pao_output_path_bench.sv
// self-checking bench for the converter output path
`timescale 1ns/1ps
`default_nettype none

module pao_output_path_bench
    import pao_pkg::*;
    ;
    logic        clk, resetn, stall, host_ready, sample_phase, hold_phase;
    logic        result_valid, accept_ready, overrun;
    logic [11:0] result_line, word_seen;
    logic [15:0] cyc_cnt, pk;
    pao_codes_t  stage_code;
    int          n_mismatch, num_checks, n;
    // stage codes per sample, stage0 in top nibble
    localparam logic [15:0] code_tbl [8] = '{16'hFFFF, 16'h9107, 16'h5111, 16'h5110,
                                             16'h1112, 16'h0000, 16'h1234, 16'h3A5C};

    pao_output_path pao_output_path_i (.clk(clk), .resetn(resetn), .stage_code(stage_code),
        .host_ready(host_ready), .sample_phase(sample_phase), .hold_phase(hold_phase),
        .result_line(result_line), .result_valid(result_valid), .accept_ready(accept_ready),
        .overrun(overrun));
    pao_host_model pao_host_model_i (.clk(clk), .resetn(resetn), .stall(stall),
        .result_line(result_line), .result_valid(result_valid), .host_ready(host_ready),
        .cyc_cnt(cyc_cnt), .word_seen(word_seen));

    // ----------------------------------------
    // clock and stage code driver
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        #1;
        for (int m = 0; m < 4; m++) begin
            n = int'(cyc_cnt) - 1 - m;
            pk = (n < 0) ? 16'h0000 : code_tbl[(n / 2) % 8];
            stage_code[4*m +: 4] = pk[12-4*m +: 4];
        end
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [11:0] exp_word(input int k);
        logic [15:0] t;
        int          s;
        t = code_tbl[k % 8];
        s = 512 * t[15:12] + 64 * t[11:8] + 8 * t[7:4] + t[3:0];
        s = s - 585;
        if (s < 0) s = 0;
        if (s > 4095) s = 4095;
        return s[11:0];
    endfunction : exp_word

    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        @(posedge clk);
        #1 resetn = 1'b0;
        repeat (2) @(posedge clk);
        check("reset_flags", {7'h00, result_valid, overrun, accept_ready, sample_phase, hold_phase}, 12'h000);
        check("reset_word", result_line, 12'h000);
        #1 resetn = 1'b1;
        $display("test reset done");
    endtask : t_reset

    task automatic t_stream();
        int c;
        repeat (40) begin
            @(negedge clk);
            c = int'(cyc_cnt);
            if (c >= 1) check("phases", {10'h000, sample_phase, hold_phase}, (c % 2) ? 12'h001 : 12'h002);
            check("flags", {10'h000, accept_ready, overrun}, (c >= 1) ? 12'h002 : 12'h000);
            if (c >= 7 && c % 2 == 1) begin
                check("result_valid", {11'h000, result_valid}, 12'h001);
                check("result_line", result_line, exp_word((c - 7) / 2));
            end
            if (c >= 8 && c % 2 == 0) check("host_word", word_seen, exp_word((c - 8) / 2));
        end
        $display("test stream done");
    endtask : t_stream

    task automatic t_stall();
        logic [11:0] held;
        int          hits;
        int          c;
        hits = 0;
        @(posedge clk);
        #1 stall = 1'b1;
        @(negedge clk);
        c = int'(cyc_cnt);
        held = exp_word((c - 7) / 2);
        repeat (14) begin
            check("held_word", result_line, held);
            if (overrun === 1'b1 && accept_ready === 1'b0) hits++;
            @(negedge clk);
        end
        check("overrun_seen", (hits > 0) ? 12'h001 : 12'h000, 12'h001);
        @(posedge clk);
        #1 stall = 1'b0;
        repeat (10) @(negedge clk);
        if (cyc_cnt[0] == 1'b0) @(negedge clk);
        c = int'(cyc_cnt);
        check("resumed", {11'h000, result_valid}, 12'h001);
        check("resumed_word", result_line, exp_word((c - 9) / 2));
        $display("test stall done");
    endtask : t_stall

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        resetn = 1'b0;
        stall = 1'b0;
        stage_code = '0;
        n_mismatch = 0;
        num_checks = 0;
        t_reset();
        t_stream();
        t_stall();
        t_reset();
        t_stream();
        final_report();
    end

    // about 120 cycles expected, allow 500
    initial begin
        #20000;
        n_mismatch++;
        final_report();
    end
endmodule : pao_output_path_bench

`default_nettype wire
